// ===== verilog/owoba_pkg.sv
// owoba_pkg: constants and carrier types for the orderwire overhead byte adapter
// assumes a 200 MHz core clock; all line and orderwire signals arrive as pins
package owoba_pkg;
   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned BIT_NS           = 15625;   // 64 kbit/s bit period
   localparam int unsigned BIT_CYCLES       = (BIT_NS * CLK_MHZ) / 1000;
   localparam int unsigned LINE_DIV         = 2430;    // line clock rising edges per 64 kHz bit
   localparam int unsigned WANDER_NS        = 18000;
   localparam int unsigned WANDER_BITS      = (WANDER_NS + BIT_NS - 1) / BIT_NS;
   // ***********************************************************
   // slip store
   // ***********************************************************
   localparam int unsigned STORE_OCTETS     = 4;
   localparam int unsigned FILL_LOW         = 1;
   localparam int unsigned FILL_HIGH        = 3;
   localparam int unsigned FILL_MID         = 2;
   localparam logic [7:0]  ALL_ONES         = 8'hFF;
   localparam logic [2:0]  BIT_LAST         = 3'h7;
   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic data;
      logic clock;
      logic octet_start;
   } owoba_orderwire_t;
   typedef struct packed {
      logic data;
      logic octet_start;
      logic signal_fail;
   } owoba_orderwire_out_t;
   typedef struct packed {
      logic clock;
      logic frame_start;
   } owoba_timing_t;
   typedef struct packed {
      logic data;
      logic clock;
      logic frame_start;
      logic trail_fail;
   } owoba_access_in_t;
endpackage : owoba_pkg

// ===== verilog/owoba_adapter.sv
// owoba_adapter: orderwire channel to and from the overhead byte of a line frame
// assumes all pin inputs are asynchronous and slower than a quarter of the core clock;
// the overhead byte is serial, msb first, in the eight line clocks after frame start
`timescale 1ns/1ps
module owoba_adapter
   import owoba_pkg::*;
#(
   parameter int unsigned DEPTH  = STORE_OCTETS,
   parameter int unsigned DIVIDE = LINE_DIV
) (
   input  wire logic                           clock,
   input  wire logic                           rstn,
   input  wire owoba_pkg::owoba_orderwire_t    orderwire_in,
   input  wire owoba_pkg::owoba_timing_t       line_timing,
   input  wire owoba_pkg::owoba_access_in_t    section_in,
   output logic                                section_access_data,
   output owoba_pkg::owoba_orderwire_out_t     orderwire_out
);
   import owoba_pkg::*;

   localparam int unsigned AW = $clog2(DEPTH);

   // depth must be a power of two and cover the wander figure plus slip margin
   if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH * 8 < 2 * WANDER_BITS) begin
      $error("owoba_adapter: DEPTH unsupported");
   end
   // the replay divider counts in twelve bits
   if (DIVIDE < 2 || DIVIDE > 4096) begin
      $error("owoba_adapter: DIVIDE unsupported");
   end

   // ***********************************************************
   // pin synchronisers: three stages, change taken when 2 and 3 agree
   // ***********************************************************
   localparam int unsigned NS = 9;
   logic [NS-1:0] pin_in;
   logic [NS-1:0] s1_reg, s2_reg, s3_reg, s1_next, s2_next, s3_next;
   logic [NS-1:0] clean_reg, clean_next, clean_prev_reg;
   assign pin_in = {section_in.data, section_in.frame_start,
                    orderwire_in.data, orderwire_in.clock, orderwire_in.octet_start,
                    line_timing.clock, line_timing.frame_start,
                    section_in.clock, section_in.trail_fail};
   always_comb begin
      s1_next = pin_in;
      s2_next = s1_reg;
      s3_next = s2_reg;
      clean_next = clean_reg;
      for (int i = 0; i < NS; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            clean_next[i] = s3_reg[i];
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         clean_reg <= '0;
         clean_prev_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         clean_reg <= clean_next;
         clean_prev_reg <= clean_reg;
      end
   end
   logic ow_d, ow_fs, ow_rise, lt_fs, lt_rise, sa_rise, sa_tsf, sa_d, sa_fs;
   assign ow_d    = clean_reg[6];
   assign ow_rise = clean_reg[5] & ~clean_prev_reg[5];
   assign ow_fs   = clean_reg[4];
   assign lt_rise = clean_reg[3] & ~clean_prev_reg[3];
   assign lt_fs   = clean_reg[2];
   assign sa_rise = clean_reg[1] & ~clean_prev_reg[1];
   assign sa_tsf  = clean_reg[0];
   // section data and frame start see the same filter delay as their clock
   assign sa_fs   = clean_reg[7];
   assign sa_d    = clean_reg[8];

   // ***********************************************************
   // source: octet assembly and slip store
   // ***********************************************************
   logic [7:0]    store_mem [DEPTH];
   logic [7:0]    asm_reg, asm_next;
   logic [2:0]    acnt_reg, acnt_next;
   logic [AW:0]   wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [AW:0]   fill;
   logic          wr_en;
   assign fill = wptr_reg - rptr_reg;
   always_comb begin
      asm_next  = asm_reg;
      acnt_next = acnt_reg;
      wptr_next = wptr_reg;
      wr_en     = 1'b0;
      if (ow_rise) begin
         asm_next = {asm_reg[6:0], ow_d};
         // whole octets only enter the store, so slips never split an octet
         // octet aligned writes
         acnt_next = ow_fs ? 3'h1 : acnt_reg + 3'h1;
         if (ow_fs && acnt_reg != 3'h0) begin
            acnt_next = 3'h1;
         end else if (acnt_reg == BIT_LAST) begin
            wr_en     = 1'b1;
            wptr_next = wptr_reg + 1'b1;
         end
      end
   end

   // ***********************************************************
   // source: per frame read with justification
   // ***********************************************************
   logic [7:0]    tx_sh_reg, tx_sh_next;
   logic [3:0]    tx_cnt_reg, tx_cnt_next;
   logic          tx_out_reg, tx_out_next;
   logic [7:0]    last_oct_reg, last_oct_next;
   logic          lt_fs_prev_reg, lt_fs_prev_next;
   always_comb begin
      rptr_next     = rptr_reg;
      lt_fs_prev_next = lt_fs_prev_reg;
      tx_sh_next    = tx_sh_reg;
      tx_cnt_next   = tx_cnt_reg;
      tx_out_next   = tx_out_reg;
      last_oct_next = last_oct_reg;
      if (lt_rise) begin
         lt_fs_prev_next = lt_fs;
         if (lt_fs && !lt_fs_prev_reg) begin
            if (fill > (AW+1)'(FILL_HIGH)) begin
               rptr_next  = rptr_reg + (AW+1)'(2);
               tx_sh_next = store_mem[AW'(rptr_reg + 1'b1)];
            end else if (fill < (AW+1)'(FILL_LOW)) begin
               tx_sh_next = last_oct_reg;
            end else begin
               rptr_next  = rptr_reg + 1'b1;
               tx_sh_next = store_mem[AW'(rptr_reg)];
            end
            last_oct_next = tx_sh_next;
            tx_cnt_next   = 4'h8;
         end
         if (tx_cnt_reg != 4'h0) begin
            tx_out_next = tx_sh_reg[7];
            tx_sh_next  = {tx_sh_reg[6:0], 1'b0};
            tx_cnt_next = tx_cnt_reg - 4'h1;
         end else begin
            tx_out_next = 1'b0;
         end
      end
   end

   // ***********************************************************
   // sink: extraction, latch, 64 kHz replay
   // ***********************************************************
   logic [7:0]    rx_sh_reg, rx_sh_next, rx_hold_reg, rx_hold_next;
   logic [3:0]    rx_cnt_reg, rx_cnt_next;
   logic [11:0]   div_reg, div_next;
   logic [7:0]    play_reg, play_next;
   logic [2:0]    pbit_reg, pbit_next;
   logic          ow_d_reg, ow_d_next, ow_fs_reg, ow_fs_next;
   logic          sa_fs_prev_reg, sa_fs_prev_next;
   always_comb begin
      rx_sh_next   = rx_sh_reg;
      rx_cnt_next  = rx_cnt_reg;
      rx_hold_next = rx_hold_reg;
      div_next     = div_reg;
      play_next    = play_reg;
      pbit_next    = pbit_reg;
      ow_d_next    = ow_d_reg;
      ow_fs_next   = ow_fs_reg;
      sa_fs_prev_next = sa_fs_prev_reg;
      if (sa_rise) begin
         sa_fs_prev_next = sa_fs;
         if (sa_fs && !sa_fs_prev_reg) begin
            rx_cnt_next = 4'h8;
         end
         if (rx_cnt_reg != 4'h0) begin
            rx_sh_next  = {rx_sh_reg[6:0], sa_d};
            rx_cnt_next = rx_cnt_reg - 4'h1;
            if (rx_cnt_reg == 4'h1) begin
               rx_hold_next = {rx_sh_reg[6:0], sa_d};
            end
         end
         // divide line clock to 64 kHz
         // alarm keeps the same bit rate
         if (div_reg == 12'(DIVIDE - 1)) begin
            div_next   = '0;
            ow_d_next  = sa_tsf ? 1'b1 : play_reg[7];
            ow_fs_next = (pbit_reg == 3'h0);
            play_next  = (pbit_reg == BIT_LAST) ? rx_hold_reg : {play_reg[6:0], 1'b0};
            pbit_next  = pbit_reg + 3'h1;
         end else begin
            div_next = div_reg + 12'h1;
         end
      end
      // the replay clock stops with the line clock; trail fail still forces ones
      if (sa_tsf) begin
         ow_d_next = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         asm_reg        <= '0;
         acnt_reg       <= '0;
         wptr_reg       <= (AW+1)'(FILL_MID);
         rptr_reg       <= '0;
         tx_sh_reg      <= '0;
         tx_cnt_reg     <= '0;
         tx_out_reg     <= 1'b0;
         last_oct_reg   <= ALL_ONES;
         lt_fs_prev_reg <= 1'b0;
         rx_sh_reg      <= '0;
         rx_cnt_reg     <= '0;
         rx_hold_reg    <= ALL_ONES;
         div_reg        <= '0;
         play_reg       <= ALL_ONES;
         pbit_reg       <= '0;
         ow_d_reg       <= 1'b1;
         ow_fs_reg      <= 1'b0;
         sa_fs_prev_reg <= 1'b0;
      end else begin
         asm_reg        <= asm_next;
         acnt_reg       <= acnt_next;
         wptr_reg       <= wptr_next;
         rptr_reg       <= rptr_next;
         tx_sh_reg      <= tx_sh_next;
         tx_cnt_reg     <= tx_cnt_next;
         tx_out_reg     <= tx_out_next;
         last_oct_reg   <= last_oct_next;
         lt_fs_prev_reg <= lt_fs_prev_next;
         rx_sh_reg      <= rx_sh_next;
         rx_cnt_reg     <= rx_cnt_next;
         rx_hold_reg    <= rx_hold_next;
         div_reg        <= div_next;
         play_reg       <= play_next;
         pbit_reg       <= pbit_next;
         ow_d_reg       <= ow_d_next;
         ow_fs_reg      <= ow_fs_next;
         sa_fs_prev_reg <= sa_fs_prev_next;
      end
   end
   // store array has no reset; pointers start half full, so the first two reads return entries never written
   // store sized for wander
   always_ff @(posedge clock) begin
      if (wr_en) store_mem[AW'(wptr_reg)] <= asm_next;
   end

   assign section_access_data       = tx_out_reg;
   assign orderwire_out.data        = ow_d_reg;
   assign orderwire_out.octet_start = ow_fs_reg;
   assign orderwire_out.signal_fail = sa_tsf;
endmodule : owoba_adapter

// ===== verification/owoba_adapter_asserts.sv
// owoba_adapter_asserts: port checks for the orderwire adapter
// assumes line clock phases of several core cycles
`timescale 1ns/1ps
module owoba_adapter_asserts
   import owoba_pkg::*;
(
   input wire logic                           clock,
   input wire logic                           rstn,
   input wire owoba_pkg::owoba_orderwire_t    orderwire_in,
   input wire owoba_pkg::owoba_timing_t       line_timing,
   input wire owoba_pkg::owoba_access_in_t    section_in,
   input wire logic                           section_access_data,
   input wire owoba_pkg::owoba_orderwire_out_t orderwire_out
);
   // rises since frame start, saturating so long frames stay quiet
   logic       lclk_reg, lclk_next;
   logic [3:0] rise_reg, rise_next;
   always_comb begin
      lclk_next = line_timing.clock;
      rise_next = rise_reg;
      if (line_timing.clock && !lclk_reg) begin
         if (line_timing.frame_start) rise_next = 4'h0;
         else if (rise_reg != 4'hF) rise_next = rise_reg + 4'h1;
      end
   end
   always_ff @(posedge clock) begin
      lclk_reg <= lclk_next;
      rise_reg <= rstn ? rise_next : 4'h0;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   ow_reset_a: assert property (disable iff (1'b0) !rstn |=>
      orderwire_out.data && !orderwire_out.signal_fail && !section_access_data)
      else $error("reset values wrong");
   fail_rise_a: assert property ($rose(section_in.trail_fail) |->
      ##[1:5] orderwire_out.signal_fail) else $error("signal fail late");
   fail_fall_a: assert property ($fell(section_in.trail_fail) |->
      ##[1:5] !orderwire_out.signal_fail) else $error("signal fail stuck");
   alarm_ones_a: assert property (section_in.trail_fail [*6] |->
      orderwire_out.data) else $error("no all ones");
   start_width_a: assert property ($rose(orderwire_out.octet_start) |->
      orderwire_out.octet_start [*8]) else $error("octet start short");
   byte_slot_a: assert property (section_access_data |->
      rise_reg >= 4'h1 && rise_reg <= 4'h9) else $error("data outside byte");
   frame_quiet_a: assert property (line_timing.frame_start |->
      !section_access_data) else $error("data at frame start");
   replay_steady_a: assert property ($changed(orderwire_out.data) &&
      $stable(section_in.trail_fail) |=> $stable(orderwire_out.data) [*8])
      else $error("replay bit too short");
endmodule : owoba_adapter_asserts
bind owoba_adapter owoba_adapter_asserts owoba_adapter_asserts_i (.clock(clock),
   .rstn(rstn), .orderwire_in(orderwire_in), .line_timing(line_timing),
   .section_in(section_in), .section_access_data(section_access_data),
   .orderwire_out(orderwire_out));

// ===== verification/owoba_line_model.sv
// owoba_line_model: line timing and received overhead stream
// assumes five core cycles per line clock phase
`timescale 1ns/1ps
module owoba_line_model
   import owoba_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rstn,
   input  wire logic [7:0]             tx_byte,
   input  wire logic [7:0]             frame_len,
   input  wire logic                   trail_fail,
   output owoba_pkg::owoba_timing_t    line_timing,
   output owoba_pkg::owoba_access_in_t section_in
);
   logic [2:0] ph = 3'h0;
   logic [7:0] pos = 8'h00;
   logic       lclk = 1'b0, fs = 1'b0, d = 1'b0;
   assign line_timing = '{clock: lclk, frame_start: fs};
   assign section_in = '{data: d, clock: lclk, frame_start: fs, trail_fail: trail_fail};
   // line clock runs free; changes land at the fall so rises see settled data
   always @(negedge clock) begin
      if (!rstn) begin
         ph <= 3'h0;
         lclk <= 1'b0;
      end else begin
         ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
         if (ph == 3'h4) begin
            lclk <= ~lclk;
            if (lclk) begin
               pos <= (pos + 8'h01 >= frame_len) ? 8'h00 : pos + 8'h01;
               fs <= (pos + 8'h01 >= frame_len);
               // byte msb first, toggling filler elsewhere
               d <= (pos < 8'h08) ? tx_byte[3'h7 - pos[2:0]] : ~d;
            end
         end
      end
   end
endmodule : owoba_line_model

// ===== verification/owoba_adapter_tb.sv
// owoba_adapter_tb: random orderwire octets against the overhead byte
// assumes fast pin rates stand in for real ones; only edges matter
`timescale 1ns/1ps
module owoba_adapter_tb;
   import owoba_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] tx_byte = 8'h00, frame_len = 8'h1C;
   logic trail_fail = 1'b0;
   owoba_orderwire_t ow_in = '0;
   owoba_timing_t line_timing;
   owoba_access_in_t section_in;
   logic section_access_data;
   owoba_orderwire_out_t ow_out;
   int n_mismatch = 0, samples_checked = 0, cycles = 0, idx = -1, warm = 4, reps, skips;
   logic [7:0] sent_q[$];
   // short replay divider keeps the sink checks inside the cycle budget
   localparam int unsigned SINK_DIV = 4;
   always #2.5 clock = ~clock;
   owoba_adapter #(.DIVIDE(SINK_DIV)) owoba_adapter_i (.clock(clock), .rstn(rstn),
      .orderwire_in(ow_in),
      .line_timing(line_timing), .section_in(section_in),
      .section_access_data(section_access_data), .orderwire_out(ow_out));
   owoba_line_model owoba_line_model_i (.clock(clock), .rstn(rstn), .tx_byte(tx_byte),
      .frame_len(frame_len), .trail_fail(trail_fail), .line_timing(line_timing),
      .section_in(section_in));
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic close_out();
      $display("mismatches %0d compared %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : check_val
   // hold one line octet for three frames, then read back the next replayed octet
   task automatic sink_round(input logic [7:0] value, output logic [7:0] got);
      @(negedge clock);
      tx_byte <= value;
      repeat (3) @(posedge line_timing.clock iff line_timing.frame_start);
      @(posedge ow_out.octet_start);
      repeat (5 * SINK_DIV) @(posedge clock);
      for (int b = 7; b >= 0; b--) begin
         got[b] = ow_out.data;
         if (b > 0) repeat (10 * SINK_DIV) @(posedge clock);
      end
   endtask : sink_round
   // walk the sent octets: next, repeat or skip, whole octets only
   task automatic run_phase(input logic [7:0] len, input int frames);
      logic [7:0] got;
      @(negedge clock);
      frame_len <= len;
      reps = 0;
      skips = 0;
      repeat (frames) begin
         @(posedge line_timing.clock iff line_timing.frame_start);
         for (int b = 7; b >= 0; b--) begin
            @(posedge line_timing.clock);
            repeat (9) @(posedge clock);
            got[b] = section_access_data;
         end
         if (warm > 0) warm--;
         else if (idx < 0) begin
            for (int j = 0; j < sent_q.size(); j++) if (sent_q[j] === got) idx = j;
         end else begin
            if (idx + 1 < sent_q.size() && got === sent_q[idx + 1]) idx++;
            else if (got === sent_q[idx]) reps++;
            else if (idx + 2 < sent_q.size() && got === sent_q[idx + 2]) begin
               idx += 2;
               skips++;
            end
            check_val(got, sent_q[idx]);
         end
      end
   endtask : run_phase
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         close_out();
      end
   end
   // orderwire source: 40 cycles a bit, corner octets 00 and FF among random ones
   initial begin
      logic [31:0] seed;
      logic [7:0]  o;
      int          k;
      seed = 32'h00000048;
      k = 0;
      repeat (8) @(negedge clock);
      forever begin
         seed = xorshift(seed);
         o = (k % 8 == 0) ? ((k % 16 == 0) ? 8'h00 : 8'hFF) : seed[7:0];
         sent_q.push_back(o);
         k++;
         for (int b = 7; b >= 0; b--) begin
            ow_in.data <= o[b];
            ow_in.octet_start <= (b == 7);
            ow_in.clock <= 1'b0;
            repeat (20) @(negedge clock);
            ow_in.clock <= 1'b1;
            repeat (20) @(negedge clock);
         end
      end
   end
   initial begin
      logic [7:0]  got;
      logic [31:0] sink_seed;
      sink_seed = xorshift(32'h00000048);
      repeat (3) @(negedge clock);
      rstn <= 1'b1;
      run_phase(8'h1C, 48);
      check_val({7'h00, reps > 0}, 8'h01);
      run_phase(8'h24, 48);
      check_val({7'h00, skips > 0}, 8'h01);
      sink_round(sink_seed[15:8], got);
      check_val(got, sink_seed[15:8]);
      sink_round(8'h00, got);
      check_val(got, 8'h00);
      @(negedge clock) trail_fail <= 1'b1;
      repeat (10) @(negedge clock);
      check_val({6'h00, ow_out.data, ow_out.signal_fail}, 8'h03);
      repeat (30 * SINK_DIV) @(negedge clock);
      check_val({7'h00, ow_out.data}, 8'h01);
      trail_fail <= 1'b0;
      repeat (10) @(negedge clock);
      check_val({7'h00, ow_out.signal_fail}, 8'h00);
      sink_round({1'b0, sink_seed[22:16]}, got);
      check_val(got, {1'b0, sink_seed[22:16]});
      close_out();
   end
endmodule : owoba_adapter_tb
